// ===== design/kg_knock_gen.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - package lasts programmable duration, 2..12000 us
// - sine of programmable frequency times envelope
// - twenty 100-ignition knock pattern tables
// - generator_on stops or runs generation
// - fire rise plays ignitions until the 100th index-0 pulse
// - fire_mode_select picks single-shot or continuous
// - dac_ref_select picks internal or external reference
// - amplitudes clamped to full scale over factor
// - output_switch connects or cuts the output
// - noise per cylinder or shared per revolution
// - random mode amplitude from probability
// - sequence mode amplitude from pattern entry
// - knock mode 0 off, 1 pattern, 2 random
// - probability 0 never to 1 always
module kg_knock_gen (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  crank_trig,  // ignition pulses per unit
  input  wire logic [4:0]  ign_index,   // ignition index of pulse
  input  wire logic        fire_input,
  output logic      [15:0] dac_data,
  output logic             dac_ref_sel,
  output logic             output_switch_on,
  output logic             pkg_busy
);
  localparam logic [31:0] DMIN = 32'(kg_pkg::DUR_MIN_US);
  localparam logic [31:0] DMAX = 32'(kg_pkg::DUR_MAX_US);
  localparam logic [4:0]  NIGN = 5'(kg_pkg::NUM_IGN);
  localparam logic [6:0]  PLEN = 7'(kg_pkg::PAT_LEN);

  // *****************************************
  // helpers
  // *****************************************
  // amplitude times factor, saturated at full scale
  function automatic logic [15:0] scale(input logic [15:0] a,
                                        input logic [15:0] f);
    logic [31:0] p;
    p = a * f;
    scale = (p[31:24] != 8'h00) ? 16'hFFFF : p[23:8];
  endfunction : scale

  function automatic logic [13:0] clip_dur(input logic [31:0] v);
    if (v < DMIN) clip_dur = 14'(DMIN);
    else if (v > DMAX) clip_dur = 14'(DMAX);
    else clip_dur = v[13:0];
  endfunction : clip_dur

  // quarter-wave sine, 8-bit signed
  function automatic logic signed [7:0] sine(input logic [5:0] ph);
    logic [3:0] i;
    logic [6:0] m;
    i = ph[4] ? ~ph[3:0] : ph[3:0];
    case (i)
      4'h0: m = 7'd6;    4'h1: m = 7'd19;
      4'h2: m = 7'd31;   4'h3: m = 7'd43;
      4'h4: m = 7'd54;   4'h5: m = 7'd65;
      4'h6: m = 7'd76;   4'h7: m = 7'd85;
      4'h8: m = 7'd94;   4'h9: m = 7'd102;
      4'hA: m = 7'd109;  4'hB: m = 7'd115;
      4'hC: m = 7'd120;  4'hD: m = 7'd123;
      4'hE: m = 7'd126;  default: m = 7'd127;
    endcase
    sine = ph[5] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction : sine

  // *****************************************
  // registers
  // *****************************************
  logic [4:0]   ctrl_q;            // control bits
  logic [1:0]   unit_q;            // crank trigger unit index
  logic [31:0]  inc_q;             // sine phase step
  logic [13:0]  dur_q;             // duration in us
  logic [15:0]  ampf_q;            // factor, 8.8
  logic [15:0]  base_q;            // base_amplitude
  logic [15:0]  noise_q;           // noise_amplitude
  logic [7:0]   env_q  [16];       // envelope points
  logic [15:0]  kamp_q [20];       // knock amplitude per ignition
  logic [1:0]   mode_q [20];       // ignition_knock_mode
  logic [15:0]  prob_q [20];       // knock_likelihood
  logic [127:0] pat_q  [20];       // pattern, bits 0..99 used

  // *****************************************
  // apb decode
  // *****************************************
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire h_ctrl = paddr == kg_pkg::OFF_CTRL;
  wire h_stat = paddr == kg_pkg::OFF_STAT;
  wire h_sinc = paddr == kg_pkg::OFF_SINC;
  wire h_dur  = paddr == kg_pkg::OFF_DUR;
  wire h_ampf = paddr == kg_pkg::OFF_AMPF;
  wire h_base = paddr == kg_pkg::OFF_BASE;
  wire h_nse  = paddr == kg_pkg::OFF_NOISE;
  wire h_env  = paddr[11:6] == kg_pkg::OFF_ENV[11:6];
  wire [4:0] ri = paddr[6:2];      // per-ignition index
  wire h_kamp = paddr[11:7] == kg_pkg::OFF_KAMP[11:7] && ri < NIGN;
  wire h_mode = paddr[11:7] == kg_pkg::OFF_MODE[11:7] && ri < NIGN;
  wire [4:0] pt = paddr[8:4];      // pattern table
  wire [1:0] pw = paddr[3:2];      // pattern word
  wire h_pat  = paddr[11:9] == kg_pkg::OFF_PAT[11:9] && pt < NIGN;
  wire hit    = h_ctrl | h_stat | h_sinc | h_dur | h_ampf | h_base
              | h_nse | h_env | h_kamp | h_mode | h_pat;

  assign pready  = 1'b1;           // zero wait states
  assign pslverr = acc & ~hit;     // unmapped access

  // *****************************************
  // configuration writes
  // *****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 5'h00;
      unit_q  <= 2'h0;
      inc_q   <= kg_pkg::SINE_INC_DEF;
      dur_q   <= 14'(kg_pkg::DUR_DEF_US);
      ampf_q  <= kg_pkg::AMPF_DEF;
      base_q  <= 16'h0000;
      noise_q <= 16'h0000;
      for (int i = 0; i < 16; i++) begin
        env_q[i] <= kg_pkg::ENV_DEF[8*i +: 8];
      end
      for (int i = 0; i < 20; i++) begin
        kamp_q[i] <= 16'h0000;
        mode_q[i] <= kg_pkg::MODE_OFF;
        prob_q[i] <= 16'h0000;
        pat_q[i]  <= 128'h0;
      end
    end else if (wr) begin
      if (h_ctrl) begin
        ctrl_q <= pwdata[4:0];
        // unit fixed while generator runs
        if (!ctrl_q[kg_pkg::CB_ON]) begin
          unit_q <= pwdata[kg_pkg::CB_UNIT +: 2];
        end
      end
      if (h_sinc) inc_q <= pwdata;
      if (h_dur) dur_q <= clip_dur(pwdata);
      if (h_ampf) ampf_q <= pwdata[15:0];
      if (h_base) base_q <= pwdata[15:0];
      if (h_nse) noise_q <= pwdata[15:0];
      if (h_env) env_q[paddr[5:2]] <= pwdata[7:0];
      if (h_kamp) kamp_q[ri] <= pwdata[15:0];
      if (h_mode) begin
        mode_q[ri] <= pwdata[17:16];
        prob_q[ri] <= pwdata[15:0];
      end
      if (h_pat) pat_q[pt][32*pw +: 32] <= pwdata;
    end
  end

  // *****************************************
  // ignition tracking
  // *****************************************
  logic        fire_q;             // previous fire_input
  logic [6:0]  left_q;             // cycles left, single shot
  logic [6:0]  pos_q;              // pattern position
  logic [15:0] lfsr_q;             // free-running noise source
  logic [15:0] rrev_q;             // per-revolution noise sample
  kg_pkg::kg_state_e st_q;         // player state
  logic [15:0] amp_q;              // latched package amplitude
  logic [31:0] ph_q;
  logic [31:0] pinc_q;             // latched phase step
  logic [21:0] slen_q;             // cycles per envelope step
  logic [21:0] cnt_q;
  logic [3:0]  ei_q;               // envelope point
  logic [15:0] dac_q;

  wire on   = ctrl_q[kg_pkg::CB_ON];
  wire fmod = ctrl_q[kg_pkg::CB_FMODE];
  wire trig = crank_trig[unit_q];
  // one pulse per cylinder; index 0 opens a cycle
  wire cyc0 = trig && ign_index == 5'h00;
  wire rise = fire_input & ~fire_q;
  wire [6:0] left_a = (cyc0 && left_q != 7'h00) ?
                      left_q - 7'h01 : left_q;
  // index-0 pulse steps the pattern position first
  wire [6:0] pos_a = !cyc0 ? pos_q :
                     (pos_q == PLEN - 7'h01) ? 7'h00 : pos_q + 7'h01;
  wire act  = fmod | (left_a != 7'h00);
  wire vidx = ign_index < NIGN;
  wire [4:0] ix = vidx ? ign_index : 5'h00;
  wire [1:0] imode = mode_q[ix];
  wire start = trig & on & act & vidx
             & (imode != kg_pkg::MODE_OFF);

  // *****************************************
  // amplitude at package start
  // *****************************************
  // shared noise takes one sample per revolution
  wire [15:0] rnd = !ctrl_q[kg_pkg::CB_SCOPE] ? lfsr_q :
                    (cyc0 ? lfsr_q : rrev_q);
  wire [15:0] sb = scale(base_q, ampf_q);
  wire [15:0] sk = scale(kamp_q[ix], ampf_q);
  wire [15:0] sn = scale(noise_q, ampf_q);
  wire pbit = pat_q[ix][pos_a];
  wire [15:0] wgt = (imode == kg_pkg::MODE_RND) ? prob_q[ix] :
                    (pbit ? 16'hFFFF : 16'h0000);
  wire signed [16:0] diff = $signed({1'b0, sk}) - $signed({1'b0, sb});
  wire signed [33:0] dw = diff * $signed({1'b0, wgt});
  wire [31:0] nz = sn * rnd;
  wire signed [18:0] asum = 19'(dw >>> 16)
                          + $signed({3'b000, sb})
                          + $signed({3'b000, nz[31:16]});
  wire [15:0] anew = asum < 0 ? 16'h0000 :
                     (asum > 19'sh0FFFF ? 16'hFFFF : asum[15:0]);
  wire [31:0] slen = 32'(dur_q) * kg_pkg::CYC_PER_US;

  // fire edge, pattern position and single-shot count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fire_q <= 1'b0;
      left_q <= 7'h00;
      pos_q  <= PLEN - 7'h01;      // first cycle at 0
    end else begin
      fire_q <= fire_input;
      if (rise && !fmod) begin
        left_q <= PLEN;
      end else begin
        left_q <= left_a;
      end
      if (rise && !fmod) pos_q <= PLEN - 7'h01;    // next cycle at 0
      else pos_q <= pos_a;
    end
  end

  // noise generator runs every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= kg_pkg::LFSR_SEED;
      rrev_q <= 16'h0000;
    end else begin
      lfsr_q <= lfsr_q[0] ? (lfsr_q >> 1) ^ kg_pkg::LFSR_TAPS
                          : lfsr_q >> 1;
      if (cyc0) rrev_q <= lfsr_q;
    end
  end

  // *****************************************
  // package player
  // *****************************************
  wire last_step = cnt_q >= slen_q - 22'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= kg_pkg::ST_IDLE;
      amp_q  <= 16'h0000;
      ph_q   <= 32'h0;
      pinc_q <= 32'h0;
      slen_q <= 22'h1;
      cnt_q  <= 22'h0;
      ei_q   <= 4'h0;
    end else if (!on) begin
      st_q <= kg_pkg::ST_IDLE;
    end else if (start) begin
      st_q   <= kg_pkg::ST_PLAY;
      amp_q  <= anew;
      pinc_q <= inc_q;
      slen_q <= slen[25:4];
      ph_q   <= 32'h0;
      cnt_q  <= 22'h0;
      ei_q   <= 4'h0;
    end else begin
      case (st_q)
        kg_pkg::ST_PLAY: begin
          ph_q <= ph_q + pinc_q;
          if (last_step) begin
            cnt_q <= 22'h0;
            if (ei_q == 4'hF) st_q <= kg_pkg::ST_IDLE;
            else ei_q <= ei_q + 4'h1;
          end else begin
            cnt_q <= cnt_q + 22'h1;
          end
        end
        default: st_q <= kg_pkg::ST_IDLE;
      endcase
    end
  end

  // *****************************************
  // sample output
  // *****************************************
  wire signed [7:0]  sv = sine(ph_q[31:26]);
  wire signed [16:0] se = sv * $signed({1'b0, env_q[ei_q]});
  wire signed [33:0] sa = se * $signed({1'b0, amp_q});
  wire playing = st_q == kg_pkg::ST_PLAY;
  wire [15:0] dac_d = (playing && ctrl_q[kg_pkg::CB_OSW]) ?
                      kg_pkg::DAC_MID + sa[31:16] :
                      kg_pkg::DAC_MID;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dac_q <= kg_pkg::DAC_MID;
    else dac_q <= dac_d;
  end

  assign dac_data         = dac_q;
  assign dac_ref_sel      = ctrl_q[kg_pkg::CB_REF];
  assign output_switch_on = ctrl_q[kg_pkg::CB_OSW];
  assign pkg_busy         = playing;

  // *****************************************
  // read mux
  // *****************************************
  always_comb begin
    prdata = 32'h0;
    if (h_ctrl) prdata = {22'h0, unit_q, 3'h0, ctrl_q};
    else if (h_stat) begin
      prdata = {11'h0, ix, 1'b0, pos_q, 6'h0, act, playing};
    end
    else if (h_sinc) prdata = inc_q;
    else if (h_dur)  prdata = {18'h0, dur_q};
    else if (h_ampf) prdata = {16'h0, ampf_q};
    else if (h_base) prdata = {16'h0, base_q};
    else if (h_nse)  prdata = {16'h0, noise_q};
    else if (h_env)  prdata = {24'h0, env_q[paddr[5:2]]};
    else if (h_kamp) prdata = {16'h0, kamp_q[ri]};
    else if (h_mode) prdata = {14'h0, mode_q[ri], prob_q[ri]};
    else if (h_pat)  prdata = pat_q[pt][32*pw +: 32];
  end
endmodule : kg_knock_gen

// ===== shared/kg_pkg.sv
package kg_pkg;
  // *****************************************
  // clock and timing
  // *****************************************
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned DUR_DEF_US = 2500;  // envelope duration
  localparam int unsigned DUR_MIN_US = 2;
  localparam int unsigned DUR_MAX_US = 12000;
  localparam int unsigned SINE_DEF_HZ = 15000;
  // phase step per clock for the default sine
  localparam logic [31:0] SINE_INC_DEF =
    32'((64'(SINE_DEF_HZ) << 32) / 64'(CLK_HZ));
  // *****************************************
  // sizes
  // *****************************************
  localparam int unsigned NUM_IGN = 20;   // ignition indices
  localparam int unsigned PAT_LEN = 100;  // ignitions per pattern
  localparam int unsigned ENV_PTS = 16;   // envelope breakpoints
  // *****************************************
  // register offsets (byte addresses)
  // *****************************************
  localparam logic [11:0] OFF_CTRL  = 12'h000;
  localparam logic [11:0] OFF_STAT  = 12'h004;
  localparam logic [11:0] OFF_SINC  = 12'h008;
  localparam logic [11:0] OFF_DUR   = 12'h00C;
  localparam logic [11:0] OFF_AMPF  = 12'h010;
  localparam logic [11:0] OFF_BASE  = 12'h014;
  localparam logic [11:0] OFF_NOISE = 12'h018;
  localparam logic [11:0] OFF_ENV   = 12'h040;  // 16 words
  localparam logic [11:0] OFF_KAMP  = 12'h100;  // 20 words
  localparam logic [11:0] OFF_MODE  = 12'h180;  // 20 words
  localparam logic [11:0] OFF_PAT   = 12'h200;  // 20 x 4 words
  // *****************************************
  // control fields
  // *****************************************
  localparam int unsigned CB_ON    = 0;  // generator_on
  localparam int unsigned CB_FMODE = 1;  // fire_mode_select
  localparam int unsigned CB_REF   = 2;  // dac_ref_select
  localparam int unsigned CB_OSW   = 3;  // output_switch
  localparam int unsigned CB_SCOPE = 4;  // noise_scope_select
  localparam int unsigned CB_UNIT  = 8;  // 2-bit trigger unit index
  localparam logic [1:0]  MODE_OFF = 2'h0;
  localparam logic [1:0]  MODE_SEQ = 2'h1;
  localparam logic [1:0]  MODE_RND = 2'h2;
  localparam logic [15:0] AMPF_DEF = 16'h0100;  // 1.0 in 8.8
  localparam logic [15:0] DAC_MID  = 16'h8000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  // default envelope, point k in bits [8k+:8]
  localparam logic [127:0] ENV_DEF =
    128'h04_06_09_0F_17_24_36_4F_71_9C_CA_F2_FE_D3_62_00;
  typedef enum logic {ST_IDLE, ST_PLAY} kg_state_e;
endpackage : kg_pkg

// ===== verif/kg_ecu_model.sv
`timescale 1ns/1ps
// ******************************
// crank pulses and dac watch
// ******************************
module kg_ecu_model (
  input  wire logic        pclk,
  input  wire logic [15:0] dac_data,
  output logic      [3:0]  crank_trig,
  output logic      [4:0]  ign_index,
  output logic             seen_q
);
  logic       go;   // pulse request
  logic [6:0] req;  // unit and index
  initial begin
    go = 1'b0;
    req = 7'h0;
    crank_trig = 4'h0;
    ign_index = 5'h0;
    seen_q = 1'b0;
  end
  // one-cycle pulse, index churns when idle
  always @(posedge pclk) begin
    crank_trig <= go ? 4'h1 << req[6:5] : 4'h0;
    ign_index  <= go ? req[4:0] : ~ign_index;
    if (dac_data !== 16'h8000) seen_q <= 1'b1;
  end
  task automatic pulse(input logic [1:0] u, input logic [4:0] i);
    @(posedge pclk);
    req <= {u, i};
    go  <= 1'b1;
    @(posedge pclk);
    go  <= 1'b0;
  endtask : pulse
  task automatic clear();
    @(negedge pclk);
    seen_q = 1'b0;
  endtask : clear
endmodule : kg_ecu_model

// ===== verif/kg_knock_chk.sv
`timescale 1ns/1ps
// ******************************
// port checker
// ******************************
module kg_knock_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  crank_trig,
  input wire logic [4:0]  ign_index,
  input wire logic        fire_input,
  input wire logic [15:0] dac_data,
  input wire logic        dac_ref_sel,
  input wire logic        output_switch_on,
  input wire logic        pkg_busy
);
  logic [3:0]  ctl_q;  // low control bits
  logic [31:0] dur_q;  // clipped duration
  logic [31:0] dur_d;  // write data clipped to 2..12000
  logic [31:0] cnt_q;  // busy cycles
  logic [31:0] len;    // package cycles
  logic        acc;    // access cycle
  assign acc   = psel && penable;
  assign dur_d = pwdata < 32'h2 ? 32'h2 :
                 pwdata > 32'h2EE0 ? 32'h2EE0 : pwdata;
  assign len   = ((dur_q * 32'hFA) >> 4) << 4;
  // shadow writes, count busy cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 4'h0;
      dur_q <= 32'h9C4;
      cnt_q <= 32'h0;
    end else begin
      if (acc && pwrite && paddr == 12'h000) ctl_q <= pwdata[3:0];
      if (acc && pwrite && paddr == 12'h00C) dur_q <= dur_d;
      cnt_q <= (|crank_trig || !pkg_busy) ? 32'h0 : cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; acc && paddr == 12'hFFC |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_cause; $rose(pkg_busy) |-> $past(crank_trig) != 4'h0;
  endproperty
  a_cause: assert property (p_cause) else $error("no pulse");
  property p_len; $fell(pkg_busy) && ctl_q[0] |->
    $past(cnt_q) == len - 32'h1; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_off; !ctl_q[0] [*2] |-> !pkg_busy; endproperty
  a_off: assert property (p_off) else $error("busy while off");
  property p_ref; dac_ref_sel == ctl_q[2]; endproperty
  a_ref: assert property (p_ref) else $error("bad ref");
  property p_osw; output_switch_on == ctl_q[3]; endproperty
  a_osw: assert property (p_osw) else $error("bad switch");
  property p_cut; !output_switch_on [*3] |-> dac_data == 16'h8000;
  endproperty
  a_cut: assert property (p_cut) else $error("cut not quiet");
endmodule : kg_knock_chk
bind kg_knock_gen kg_knock_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .crank_trig(crank_trig),
  .ign_index(ign_index), .fire_input(fire_input), .dac_data(dac_data),
  .dac_ref_sel(dac_ref_sel), .output_switch_on(output_switch_on),
  .pkg_busy(pkg_busy));

// ===== verif/tb_knock_signal_generator.sv
`timescale 1ns/1ps
// ******************************
// bench
// ******************************
module tb_knock_signal_generator;
  logic        pclk, presetn, psel, penable, pwrite, fire_input;
  logic        pready, pslverr, pkg_busy, seen, ref_sel, osw_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  crank_trig;
  logic [4:0]  ign_index;
  logic [15:0] dac_data;
  int          fail_count, tests_run, cyc;
  always #2 pclk = ~pclk;
  kg_knock_gen DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crank_trig(crank_trig),
    .ign_index(ign_index), .fire_input(fire_input), .dac_data(dac_data),
    .dac_ref_sel(ref_sel), .output_switch_on(osw_on),
    .pkg_busy(pkg_busy));
  kg_ecu_model ecu (
    .pclk(pclk), .dac_data(dac_data), .crank_trig(crank_trig),
    .ign_index(ign_index), .seen_q(seen));
  task automatic check(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, x);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
  endtask : rdc
  // pulse a unit, judge start and output activity
  task automatic pkg(input logic [1:0] u, input logic b, input logic v);
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    ecu.clear();
    ecu.pulse(u, 5'h00);
    @(posedge pclk);
    @(negedge pclk);
    check(32'(pkg_busy), 32'(b));
    while (pkg_busy === 1'b1 && n < 13000) begin
      @(negedge pclk);
      n++;
    end
    check(32'(pkg_busy), 32'h0);
    check(32'(seen), 32'(v));
  endtask : pkg
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rdc(12'h000, 32'h0);
    rdc(12'h00C, 32'h9C4);
    rdc(12'h008, kg_pkg::SINE_INC_DEF);
    rdc(12'h010, {16'h0, kg_pkg::AMPF_DEF});
    wr(12'h00C, 32'h1);
    rdc(12'h00C, 32'h2);
    wr(12'h00C, 32'h4E20);
    rdc(12'h00C, 32'h2EE0);
    apb(1'b0, 12'hFFC, 32'h0, q, e);
    check(32'(e), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, 32'(i) << 2);
      @(negedge pclk);
      check(32'(ref_sel), 32'(i & 1));
      check(32'(osw_on), 32'(i >> 1));
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes();
    wr(12'h008, 32'h00053E2D);
    wr(12'h00C, 32'h32);
    wr(12'h040, 32'h0);
    rdc(12'h040, 32'h0);
    wr(12'h100, 32'hFFFF);
    wr(12'h000, 32'h1B);
    wr(12'h180, {14'h0, kg_pkg::MODE_OFF, 16'hFFFF});
    pkg(2'h0, 1'b0, 1'b0);
    wr(12'h180, {14'h0, kg_pkg::MODE_SEQ, 16'h0});
    pkg(2'h0, 1'b1, 1'b0);
    wr(12'h180, {14'h0, kg_pkg::MODE_RND, 16'h0});
    pkg(2'h0, 1'b1, 1'b0);
    wr(12'h180, {14'h0, kg_pkg::MODE_RND, 16'hFFFF});
    pkg(2'h0, 1'b1, 1'b1);
    for (int w = 0; w < 4; w++) wr(12'h200 + 12'(4 * w), 32'hFFFFFFFF);
    wr(12'h180, {14'h0, kg_pkg::MODE_SEQ, 16'h0});
    pkg(2'h0, 1'b1, 1'b1);
    wr(12'h000, 32'h3);
    pkg(2'h0, 1'b1, 1'b0);
    wr(12'h000, 32'h9);
    pkg(2'h0, 1'b0, 1'b0);
    @(posedge pclk);
    fire_input <= 1'b1;
    pkg(2'h0, 1'b1, 1'b1);
    @(posedge pclk);
    fire_input <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_unit();
    wr(12'h000, 32'h100);
    wr(12'h000, 32'h10B);
    pkg(2'h0, 1'b0, 1'b0);
    pkg(2'h1, 1'b1, 1'b1);
    ecu.pulse(2'h1, 5'h00);
    repeat (50) @(posedge pclk);
    wr(12'h000, 32'h00A);
    repeat (2) @(negedge pclk);
    check(32'(pkg_busy), 32'h0);
    rdc(12'h000, 32'h10A);
    $display("test unit done");
  endtask : t_unit
  initial begin
    {pclk, presetn, psel, penable, pwrite, fire_input} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_unit();
    test_done();
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      test_done();
    end
  end
endmodule : tb_knock_signal_generator
